// file: rtl/tsf_byte_fifo.v
// Purpose: byte FIFO moving up to four bytes in and out per clock
// Assumes: caller never pushes past free space nor pops past count
// Notes: each entry is a byte plus one mark bit
`timescale 1ns/10ps
`include "tsf_map.vh"

module tsf_byte_fifo (
    input wire ref_clk,
    input wire rstn,
    input wire clear,
    input wire [2:0] pushCnt,
    input wire [35:0] pushData,
    input wire [2:0] popCnt,
    output reg [35:0] headData,
    output reg [9:0] count
);

reg [8:0] mem [0:`TSF_FIFO_DEPTH-1];
reg [`TSF_FIFO_AW-1:0] wrPtr;
reg [`TSF_FIFO_AW-1:0] rdPtr;
// each process keeps its own loop index so neither wakes the other
integer iw;
integer ir;

// storage has no reset; only pointers define content
always @(posedge ref_clk) begin
    for (iw = 0; iw < 4; iw = iw + 1) begin
        if (!clear && iw < pushCnt) begin
            mem[wrPtr + iw[`TSF_FIFO_AW-1:0]] <= pushData[iw*9 +: 9];
        end
    end
end

// four head entries seen at once for multi-byte pops
always @* begin
    headData = 36'h0;
    for (ir = 0; ir < 4; ir = ir + 1) begin
        headData[ir*9 +: 9] = mem[rdPtr + ir[`TSF_FIFO_AW-1:0]];
    end
end

// pointers wrap on the power-of-two depth
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        wrPtr <= 9'h0;
        rdPtr <= 9'h0;
        count <= 10'h0;
    end else if (clear) begin
        wrPtr <= 9'h0;
        rdPtr <= 9'h0;
        count <= 10'h0;
    end else begin
        wrPtr <= wrPtr + {6'h0, pushCnt};
        rdPtr <= rdPtr + {6'h0, popCnt};
        count <= count + {7'h0, pushCnt} - {7'h0, popCnt};
    end
end

endmodule // tsf_byte_fifo

// file: rtl/tsf_fifo_ports.v
// Purpose: host-side FIFO data ports, transmit completion store, free space
// Assumes: ioRd/ioWr are one-cycle strobes synchronous to ref_clk
// Notes: read data appears on ioRdata the cycle after the strobe
//
// What this block does
// - eight-bit status: done, irq, jabber, underrun, collisions, overflow
// - store entry on failure or requested success interrupt
// - completion bit clear while store is empty
// - status write with completion set pops entry
// - empty store drops transmit-complete flag
// - any error disables transmitter until enable command
// - packet gone at completion; later writes harmless
// - transmit free count may lag one cycle
// - irq bit copies the packet preamble request
// - 31 entries; full sets overflow, disables, write clears
// - word read pops word, low byte read pops byte
// - dword read pops two words, earlier in low half
// - word write pushes word, low byte pushes byte
// - dword write pushes low half then high half
// - dword pops dword; offset two alone acts sixteen-bit
// - free receive count in bits 14..0, zero when full
// - free count equals capacity after receiver reset
// - discard drops rest of current packet and padding
`timescale 1ns/10ps
`include "tsf_map.vh"

module tsf_fifo_ports (
    input wire ref_clk,
    input wire rstn,
    input wire ioRd,
    input wire ioWr,
    input wire [3:0] ioAddr,
    input wire [1:0] ioSize,
    input wire [31:0] ioWdata,
    output reg [31:0] ioRdata,
    input wire cmdTxEnable,
    input wire cmdTxReset,
    input wire cmdRxReset,
    input wire cmdRxDiscard,
    input wire rxNetValid,
    input wire [7:0] rxNetByte,
    input wire rxNetLast,
    output reg rxNetReady,
    output reg txNetValid,
    output reg [7:0] txNetByte,
    input wire txNetTake,
    input wire txDoneValid,
    input wire txDoneIrqReq,
    input wire txDoneJabber,
    input wire txDoneUnderrun,
    input wire txDoneMaxColl,
    output reg txEnabled,
    output reg txCompleteFlag,
    output reg [15:0] txSpaceCount,
    output reg rxDiscardBusy
);

// one-hot discard machine states
localparam ST_IDLE = 2'b01;
localparam ST_DISC = 2'b10;

reg [1:0] state;
reg [1:0] next_state;
reg [1:0] rxPhase;
reg [14:0] rxSpace;
reg errDisabled;
reg overflowFlag;
reg [2:0] rxPushCnt;
reg [35:0] rxPushData;
reg [2:0] rxPopCnt;
reg [2:0] txPushCnt;
reg [35:0] txPushData;
reg [2:0] txPopCnt;
reg [31:0] next_rdata;
reg [7:0] visibleStatus;
reg found;
wire [35:0] rxHead;
wire [35:0] txHead;
wire [9:0] rxCount;
wire [9:0] txCount;
wire [7:0] queueHead;
wire [4:0] queueCount;
wire [9:0] txFree;
wire [2:0] rxAvail4;
wire [2:0] accN;
wire dataAddr;
wire errEvent;
wire statusPush;
wire statusWrite;
wire statusPop;
wire txFlush;
wire loadOut;
wire next_errDisabled;
wire next_overflow;
// one loop index per process: a shared one would retrigger them endlessly
integer iPush;
integer iDisc;
integer iTx;
integer iRd;

// bytes moved by one access of the given size
function [2:0] accBytes(input [1:0] sz);
    begin
        case (sz)
            `TSF_SZ_BYTE: accBytes = 3'h1;
            `TSF_SZ_WORD: accBytes = 3'h2;
            default: accBytes = 3'h4;
        endcase
    end
endfunction

// limit a byte count to what the FIFO holds
function [2:0] clip(input [2:0] n, input [9:0] avail);
    begin
        clip = (avail < {7'h0, n}) ? avail[2:0] : n;
    end
endfunction

// both data offsets act alike for byte and word; dword only from offset zero; odd bytes refused
assign dataAddr = (ioAddr == `TSF_OFS_DATA0) ||
                  (ioAddr == `TSF_OFS_DATA1 && ioSize != `TSF_SZ_DWORD);
assign accN = accBytes(ioSize);
assign rxAvail4 = clip(3'h4, rxCount);
assign txFree = `TSF_FIFO_DEPTH - txCount;

// completion events from the transmitter
assign errEvent = txDoneValid && (txDoneJabber || txDoneUnderrun || txDoneMaxColl);
assign statusPush = txDoneValid && (errEvent || txDoneIrqReq)
                    && queueCount != `TSF_QUEUE_DEPTH;
assign statusWrite = ioWr && ioAddr == `TSF_OFS_TXSTAT;
assign statusPop = statusWrite && visibleStatus[`TSF_ST_COMPLETION];
assign txFlush = cmdTxReset || errEvent;

// disable causes: an error wins over a same-cycle enable; a same-cycle status write blocks the overflow set
assign next_errDisabled = errEvent || (errDisabled && !cmdTxEnable);
assign next_overflow = (statusPush && !statusPop && queueCount == `TSF_QUEUE_ALMOST)
                       || (overflowFlag && !statusWrite);
assign loadOut = txEnabled && !txFlush && txCount != 10'h0 && (!txNetValid || txNetTake);

// visible entry: completion bit only while entries wait
always @* begin
    visibleStatus = 8'h0;
    if (queueCount != 5'h0) begin
        visibleStatus = queueHead;
    end
    visibleStatus[`TSF_ST_OVERFLOW] = overflowFlag;
end

// receive side push: last byte carries the dword padding with it
always @* begin
    rxPushCnt = 3'h0;
    rxPushData = 36'h0;
    if (rxNetValid && rxNetReady && !cmdRxReset) begin
        rxPushCnt = rxNetLast ? (3'h4 - {1'b0, rxPhase}) : 3'h1;
        rxPushData[7:0] = rxNetByte;
        rxPushData[8] = rxNetLast && rxPhase == 2'h3;
        for (iPush = 1; iPush < 4; iPush = iPush + 1) begin
            rxPushData[iPush*9 + 8] = rxNetLast && (iPush == 3 - rxPhase);
        end
    end
end

// receive pops: discard walks to the packet's end mark, else host reads
always @* begin
    rxPopCnt = 3'h0;
    next_state = state;
    found = 1'b0;
    case (state)
        ST_IDLE: begin
            if (cmdRxDiscard) begin
                next_state = ST_DISC;
            end else if (ioRd && dataAddr) begin
                rxPopCnt = clip(accN, rxCount);
            end
        end
        ST_DISC: begin
            rxPopCnt = rxAvail4;
            for (iDisc = 3; iDisc >= 0; iDisc = iDisc - 1) begin
                if (iDisc < rxAvail4 && rxHead[iDisc*9 + 8]) begin
                    rxPopCnt = iDisc[2:0] + 3'h1;
                    found = 1'b1;
                end
            end
            // an empty FIFO also ends it: nothing left to drop
            if (found || rxCount == 10'h0) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
    if (cmdRxReset) begin
        rxPopCnt = 3'h0;
        next_state = ST_IDLE;
    end
end

// transmit pushes: dropped while error-disabled, never overfilled
always @* begin
    txPushCnt = 3'h0;
    txPushData = 36'h0;
    if (ioWr && dataAddr && !errDisabled && !txFlush && txFree >= {7'h0, accN}) begin
        txPushCnt = accN;
        for (iTx = 0; iTx < 4; iTx = iTx + 1) begin
            txPushData[iTx*9 +: 8] = ioWdata[iTx*8 +: 8];
        end
    end
    txPopCnt = loadOut ? 3'h1 : 3'h0;
end

// read data: earlier bytes in the low lanes, unused lanes zero
always @* begin
    next_rdata = 32'h0;
    if (ioAddr == `TSF_OFS_RXSPACE) begin
        next_rdata[15:0] = {1'b0, rxSpace};
    end else if (ioAddr == `TSF_OFS_TXSTAT) begin
        next_rdata[7:0] = visibleStatus;
    end else if (dataAddr && state == ST_IDLE) begin
        // bytes dropped by a discard walk are never shown to the host
        for (iRd = 0; iRd < 4; iRd = iRd + 1) begin
            if (iRd < rxPopCnt) begin
                next_rdata[iRd*8 +: 8] = rxHead[iRd*9 +: 8];
            end
        end
    end
end

tsf_byte_fifo rxFifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clear(cmdRxReset),
    .pushCnt(rxPushCnt),
    .pushData(rxPushData),
    .popCnt(rxPopCnt),
    .headData(rxHead),
    .count(rxCount)
);

tsf_byte_fifo txFifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clear(txFlush),
    .pushCnt(txPushCnt),
    .pushData(txPushData),
    .popCnt(txPopCnt),
    .headData(txHead),
    .count(txCount)
);

tsf_status_queue statusQueue (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .push(statusPush),
    .pushData({1'b1, txDoneIrqReq, txDoneJabber, txDoneUnderrun,
               txDoneMaxColl, 3'h0}),
    .pop(statusPop),
    .headData(queueHead),
    .count(queueCount)
);

// control state, counts and registered outputs
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        state <= ST_IDLE;
        rxPhase <= 2'h0;
        rxSpace <= 15'h0;
        errDisabled <= 1'b0;
        overflowFlag <= 1'b0;
        ioRdata <= 32'h0;
        rxNetReady <= 1'b0;
        txNetValid <= 1'b0;
        txNetByte <= 8'h0;
        txEnabled <= 1'b0;
        txCompleteFlag <= 1'b0;
        txSpaceCount <= 16'h0;
        rxDiscardBusy <= 1'b0;
    end else begin
        state <= next_state;
        rxDiscardBusy <= next_state == ST_DISC;
        if (cmdRxReset) begin
            rxPhase <= 2'h0;
        end else if (rxPushCnt != 3'h0) begin
            rxPhase <= rxNetLast ? 2'h0 : rxPhase + 2'h1;
        end
        // free counts are snapshots, so they trail the FIFO by a cycle
        rxSpace <= {5'h0, `TSF_FIFO_DEPTH - rxCount};
        rxNetReady <= (`TSF_FIFO_DEPTH - rxCount) >= `TSF_RX_MARGIN;
        txSpaceCount <= {6'h0, txFree};
        errDisabled <= next_errDisabled;
        overflowFlag <= next_overflow;
        txEnabled <= !next_errDisabled && !next_overflow;
        txCompleteFlag <= (queueCount + {4'h0, statusPush} - {4'h0, statusPop})
                          != 5'h0;
        if (ioRd) begin
            ioRdata <= next_rdata;
        end
        // single-byte output stage toward the transmitter
        if (txFlush) begin
            txNetValid <= 1'b0;
        end else if (loadOut) begin
            txNetValid <= 1'b1;
            txNetByte <= txHead[7:0];
        end else if (txNetTake) begin
            txNetValid <= 1'b0;
        end
    end
end

endmodule // tsf_fifo_ports

// file: rtl/tsf_map.vh
// Purpose: offsets, field positions, sizes and depths of the FIFO port block
// Assumes: byte addressed I/O port cycles of one clock each
// Notes: definitions only
`ifndef TSF_MAP_VH
`define TSF_MAP_VH

// port offsets inside the register window
`define TSF_OFS_DATA0 4'h0
`define TSF_OFS_DATA1 4'h2
`define TSF_OFS_RXSPACE 4'ha
`define TSF_OFS_TXSTAT 4'hb

// access size codes on ioSize
`define TSF_SZ_BYTE 2'h0
`define TSF_SZ_WORD 2'h1
`define TSF_SZ_DWORD 2'h2

// transmit status entry bit positions
`define TSF_ST_COMPLETION 7
`define TSF_ST_IRQREQ 6
`define TSF_ST_JABBER 5
`define TSF_ST_UNDERRUN 4
`define TSF_ST_MAXCOLL 3
`define TSF_ST_OVERFLOW 2

// storage sizes
`define TSF_FIFO_DEPTH 10'h200
`define TSF_FIFO_AW 9
`define TSF_QUEUE_DEPTH 5'h1f
`define TSF_QUEUE_ALMOST 5'h1e

// receive ready margin: one cycle of lag times four bytes, doubled
`define TSF_RX_MARGIN 10'h008

`endif

// file: rtl/tsf_status_queue.v
// Purpose: 31-entry store of transmit completion entries, oldest first
// Assumes: push only while not full, pop only while not empty
// Notes: same-cycle push and pop keep the count
`timescale 1ns/10ps
`include "tsf_map.vh"

module tsf_status_queue (
    input wire ref_clk,
    input wire rstn,
    input wire push,
    input wire [7:0] pushData,
    input wire pop,
    output wire [7:0] headData,
    output reg [4:0] count
);

reg [7:0] mem [0:`TSF_QUEUE_DEPTH-1];
reg [4:0] wrIdx;
reg [4:0] rdIdx;

// depth is not a power of two, so indices wrap by compare
function [4:0] bump(input [4:0] idx);
    begin
        bump = (idx == `TSF_QUEUE_DEPTH - 5'h1) ? 5'h0 : idx + 5'h1;
    end
endfunction

assign headData = mem[rdIdx];

always @(posedge ref_clk) begin
    if (push) begin
        mem[wrIdx] <= pushData;
    end
end

// index and count bookkeeping
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        wrIdx <= 5'h0;
        rdIdx <= 5'h0;
        count <= 5'h0;
    end else begin
        if (push) begin
            wrIdx <= bump(wrIdx);
        end
        if (pop) begin
            rdIdx <= bump(rdIdx);
        end
        count <= count + {4'h0, push} - {4'h0, pop};
    end
end

endmodule // tsf_status_queue

// file: tb/tsf_fifo_ports_chk.sv
// Purpose: port-level checks of the FIFO port block
// Assumes: one-cycle host strobes, read data one cycle late
// Notes: bound into tsf_fifo_ports
`timescale 1ns/10ps
`include "tsf_map.vh"

module tsf_fifo_ports_chk (
    input wire ref_clk,
    input wire rstn,
    input wire ioRd,
    input wire ioWr,
    input wire [3:0] ioAddr,
    input wire [31:0] ioRdata,
    input wire cmdTxEnable,
    input wire txNetValid,
    input wire txDoneValid,
    input wire txDoneIrqReq,
    input wire txDoneJabber,
    input wire txDoneUnderrun,
    input wire txDoneMaxColl,
    input wire txEnabled,
    input wire txCompleteFlag,
    input wire [15:0] txSpaceCount
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // decoded causes shared by several checks
    wire txErr = txDoneValid && (txDoneJabber || txDoneUnderrun || txDoneMaxColl);
    wire statRd = ioRd && (ioAddr == `TSF_OFS_TXSTAT);
    wire statWr = ioWr && (ioAddr == `TSF_OFS_TXSTAT);

    a_error_stops_tx: assert property (txErr |=> !txEnabled)
        else $error("transmitter on after error");
    // past reset guard: enable rises by itself on the first edge
    a_tx_stays_off: assert property (
        $past(rstn) && !txEnabled && !cmdTxEnable && !statWr |=> !txEnabled)
        else $error("transmitter back without enable");
    a_push_on_report: assert property (
        txErr || (txDoneValid && txDoneIrqReq) |=> txCompleteFlag)
        else $error("reported completion not stored");
    a_quiet_success: assert property (
        txDoneValid && !txErr && !txDoneIrqReq && !txCompleteFlag |=> !txCompleteFlag)
        else $error("plain success was stored");
    a_empty_clear_bit: assert property (
        statRd && !txCompleteFlag && !txDoneValid |=> !ioRdata[`TSF_ST_COMPLETION])
        else $error("completion bit set on empty store");
    a_flag_shows_bit: assert property (
        statRd && txCompleteFlag |=> ioRdata[`TSF_ST_COMPLETION])
        else $error("completion bit missing");
    a_rx_space_range: assert property (
        ioRd && ioAddr == `TSF_OFS_RXSPACE |=> ioRdata[15:0] <= 16'h0200)
        else $error("free receive count out of range");
    a_flush_on_error: assert property (txErr |=> !txNetValid)
        else $error("byte still offered after error");
    a_space_restored: assert property (
        txErr |-> ##[1:2] txSpaceCount == 16'h0200)
        else $error("transmit space not restored");
    a_read_holds: assert property (!ioRd |=> $stable(ioRdata))
        else $error("read data moved without read");

    c_pop: cover property (statWr && txCompleteFlag);
    c_error: cover property (txErr);
    c_data_read: cover property (ioRd && ioAddr == `TSF_OFS_DATA0);
endmodule // tsf_fifo_ports_chk

bind tsf_fifo_ports tsf_fifo_ports_chk chk_u (.ref_clk(ref_clk), .rstn(rstn), .ioRd(ioRd),
    .ioWr(ioWr), .ioAddr(ioAddr), .ioRdata(ioRdata), .cmdTxEnable(cmdTxEnable),
    .txNetValid(txNetValid), .txDoneValid(txDoneValid), .txDoneIrqReq(txDoneIrqReq),
    .txDoneJabber(txDoneJabber), .txDoneUnderrun(txDoneUnderrun),
    .txDoneMaxColl(txDoneMaxColl), .txEnabled(txEnabled),
    .txCompleteFlag(txCompleteFlag), .txSpaceCount(txSpaceCount));

// file: tb/tsf_fifo_ports_tb.sv
// Purpose: self-checking bench of the FIFO port block
// Assumes: host cycles one strobe cycle plus one idle cycle
// Notes: network side played by tsf_net_model
`timescale 1ns/10ps
`include "tsf_map.vh"

module tsf_fifo_ports_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ioRd = 1'b0;
    logic ioWr = 1'b0;
    logic [3:0] ioAddr = 4'h0;
    logic [1:0] ioSize = 2'h0;
    logic [31:0] ioWdata = 32'h0;
    logic [3:0] cmd = 4'h0;
    wire [31:0] ioRdata;
    wire rxNetValid, rxNetLast, rxNetReady, txNetValid, txNetTake, txDoneValid;
    wire [7:0] rxNetByte, txNetByte;
    wire [3:0] txDoneFlags;
    wire txEnabled, txCompleteFlag, rxDiscardBusy;
    wire [15:0] txSpaceCount;
    logic [31:0] v, s0;
    logic [3:0] f;
    logic [63:0] txExp = 64'h5544332211ccbbaa;
    int fails = 0;
    int tests_run = 0;
    int i, k;

    always #2.5 ref_clk = ~ref_clk;

    tsf_fifo_ports dut_u (.ref_clk(ref_clk), .rstn(rstn), .ioRd(ioRd), .ioWr(ioWr),
        .ioAddr(ioAddr), .ioSize(ioSize), .ioWdata(ioWdata), .ioRdata(ioRdata),
        .cmdTxEnable(cmd[0]), .cmdTxReset(cmd[1]), .cmdRxReset(cmd[2]),
        .cmdRxDiscard(cmd[3]), .rxNetValid(rxNetValid), .rxNetByte(rxNetByte),
        .rxNetLast(rxNetLast), .rxNetReady(rxNetReady), .txNetValid(txNetValid),
        .txNetByte(txNetByte), .txNetTake(txNetTake), .txDoneValid(txDoneValid),
        .txDoneIrqReq(txDoneFlags[3]), .txDoneJabber(txDoneFlags[2]),
        .txDoneUnderrun(txDoneFlags[1]), .txDoneMaxColl(txDoneFlags[0]),
        .txEnabled(txEnabled), .txCompleteFlag(txCompleteFlag),
        .txSpaceCount(txSpaceCount), .rxDiscardBusy(rxDiscardBusy));

    tsf_net_model net_u (.ref_clk(ref_clk), .rxNetReady(rxNetReady),
        .rxNetValid(rxNetValid), .rxNetByte(rxNetByte), .rxNetLast(rxNetLast),
        .txNetValid(txNetValid), .txNetByte(txNetByte), .txEnabled(txEnabled),
        .txNetTake(txNetTake), .txDoneValid(txDoneValid), .txDoneFlags(txDoneFlags));

    // one host cycle; idle cycle after so strobes never double up
    task automatic io(input logic wr, input logic [3:0] a, input logic [1:0] s,
            input logic [31:0] d);
        @(negedge ref_clk);
        ioRd = !wr;
        ioWr = wr;
        ioAddr = a;
        ioSize = s;
        ioWdata = d;
        @(negedge ref_clk);
        ioRd = 1'b0;
        ioWr = 1'b0;
        v = ioRdata;
    endtask

    task automatic pulse(input int b);
        @(negedge ref_clk);
        cmd[b] = 1'b1;
        @(negedge ref_clk);
        cmd = 4'h0;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles used
    initial begin
        #200000;
        fails++;
        final_report();
    end

    initial begin
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (2) @(negedge ref_clk);
        io(0, `TSF_OFS_RXSPACE, `TSF_SZ_WORD, 32'h0);
        chk("rx space", 32'h200, 32'(v[15:0]));
        chk("tx on", 32'h1, 32'(txEnabled));
        chk("rx ready", 32'h1, 32'(rxNetReady));
        $display("test reset done");
        // receive: refused high byte, word, byte, dword, then discard
        net_u.send(6);
        repeat (4) @(negedge ref_clk);
        io(0, `TSF_OFS_RXSPACE, `TSF_SZ_WORD, 32'h0);
        chk("rx space", 32'h1f8, 32'(v[15:0]));
        io(0, 4'h1, `TSF_SZ_BYTE, 32'h0);
        chk("high byte", 32'h0, v);
        io(0, `TSF_OFS_DATA0, `TSF_SZ_WORD, 32'h0);
        chk("rx word", 32'h0201, 32'(v[15:0]));
        io(0, `TSF_OFS_DATA0, `TSF_SZ_BYTE, 32'h0);
        chk("rx byte", 32'h03, 32'(v[7:0]));
        io(0, `TSF_OFS_DATA0, `TSF_SZ_DWORD, 32'h0);
        chk("rx dword", 32'h00060504, v);
        pulse(3); // skip the pad byte left over
        chk("discard busy", 32'h1, 32'(rxDiscardBusy));
        for (i = 0; i < 50 && rxDiscardBusy !== 1'b0; i++) @(negedge ref_clk);
        chk("discard busy", 32'h0, 32'(rxDiscardBusy));
        net_u.send(4);
        repeat (4) @(negedge ref_clk);
        io(0, `TSF_OFS_DATA1, `TSF_SZ_DWORD, 32'h0);
        chk("rx dword 2", 32'h0, v);
        io(0, `TSF_OFS_DATA1, `TSF_SZ_WORD, 32'h0);
        chk("rx word 2", 32'h0201, 32'(v[15:0]));
        io(0, `TSF_OFS_DATA0, `TSF_SZ_WORD, 32'h0);
        chk("rx word 0", 32'h0403, 32'(v[15:0]));
        repeat (2) @(negedge ref_clk);
        io(0, `TSF_OFS_RXSPACE, `TSF_SZ_WORD, 32'h0);
        chk("rx space", 32'h200, 32'(v[15:0]));
        // a three-byte frame then a receiver reset leaves the FIFO empty
        net_u.send(3);
        pulse(2); // receiver reset
        repeat (2) @(negedge ref_clk);
        io(0, `TSF_OFS_RXSPACE, `TSF_SZ_WORD, 32'h0);
        chk("rx space", 32'h200, 32'(v[15:0]));
        $display("test receive done");
        // transmit: sizes decrement space, order on the wire, eight bytes in all
        io(1, `TSF_OFS_DATA0, `TSF_SZ_BYTE, 32'h000000aa);
        // first byte moves on to the output stage; free count trails a cycle
        repeat (2) @(negedge ref_clk);
        s0 = 32'(txSpaceCount);
        io(1, `TSF_OFS_DATA0, `TSF_SZ_WORD, 32'h0000ccbb);
        @(negedge ref_clk);
        chk("tx space", s0 - 32'h2, 32'(txSpaceCount));
        io(1, `TSF_OFS_DATA0, `TSF_SZ_DWORD, 32'h44332211);
        @(negedge ref_clk);
        chk("tx space", s0 - 32'h6, 32'(txSpaceCount));
        io(1, `TSF_OFS_DATA1, `TSF_SZ_BYTE, 32'h00000055);
        @(negedge ref_clk);
        chk("tx space", s0 - 32'h7, 32'(txSpaceCount));
        net_u.hold = 1'b0;
        repeat (30) @(negedge ref_clk);
        chk("tx count", 32'h8, 32'(net_u.got.size()));
        for (i = 0; i < 8; i++) begin
            chk("tx byte", 32'(txExp[8*i +: 8]), 32'(net_u.got[i]));
        end
        chk("tx space", 32'h200, 32'(txSpaceCount));
        $display("test transmit done");
        // completions: stored success, unstored success, then each error code
        net_u.report(4'h8);
        net_u.report(4'h0);
        io(0, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        chk("status", 32'hc0, 32'(v[7:0]));
        io(1, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        chk("complete flag", 32'h0, 32'(txCompleteFlag));
        io(0, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        chk("status empty", 32'h0, 32'(v[7]));
        for (k = 0; k < 3; k++) begin
            f = 4'h4 >> k;
            net_u.report(f);
            io(1, `TSF_OFS_DATA0, `TSF_SZ_WORD, 32'h00001234);
            chk("tx space", 32'h200, 32'(txSpaceCount));
            chk("tx off", 32'h0, 32'(txEnabled));
            io(0, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
            chk("status", 32'h80 | (32'(f) << 3), 32'(v[7:0]));
            io(1, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
            if (f != 4'h1) pulse(1); // reset needed after jabber or underrun
            pulse(0);
            @(negedge ref_clk);
            chk("tx on", 32'h1, 32'(txEnabled));
        end
        $display("test completion done");
        // full store of 31 stops the transmitter until a status write
        for (i = 0; i < 31; i++) net_u.report(4'h8);
        chk("tx off full", 32'h0, 32'(txEnabled));
        io(0, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        chk("status full", 32'hc4, 32'(v[7:0]));
        io(1, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        @(negedge ref_clk);
        chk("tx on", 32'h1, 32'(txEnabled));
        for (i = 0; i < 30; i++) io(1, `TSF_OFS_TXSTAT, `TSF_SZ_BYTE, 32'h0);
        chk("complete flag", 32'h0, 32'(txCompleteFlag));
        $display("test overflow done");
        final_report();
    end
endmodule // tsf_fifo_ports_tb

// file: tb/tsf_net_model.sv
// Purpose: network side of the FIFO port block
// Assumes: drives at the falling edge
// Notes: hold stalls the transmit take; got keeps taken bytes
`timescale 1ns/10ps

module tsf_net_model (
    input wire ref_clk,
    input wire rxNetReady,
    output logic rxNetValid,
    output logic [7:0] rxNetByte,
    output logic rxNetLast,
    input wire txNetValid,
    input wire [7:0] txNetByte,
    input wire txEnabled,
    output logic txNetTake,
    output logic txDoneValid,
    output logic [3:0] txDoneFlags
);
    logic hold = 1'b1;
    logic [7:0] got [$];

    // idle levels; byte line is scrambled outside frames
    initial begin
        rxNetValid = 1'b0;
        rxNetByte = 8'h5a;
        rxNetLast = 1'b0;
        txNetTake = 1'b0;
        txDoneValid = 1'b0;
        txDoneFlags = 4'h0;
    end

    // take only while allowed to run, so a stall really backs up
    always @(negedge ref_clk) txNetTake <= txNetValid && txEnabled && !hold;
    always @(posedge ref_clk) if (txNetValid && txNetTake) got.push_back(txNetByte);

    // one frame of bytes 1..n, waiting on ready
    task automatic send(input int n);
        int i;
        i = 0;
        while (i < n) begin
            @(negedge ref_clk);
            rxNetValid = 1'b1;
            rxNetByte = 8'(i + 1);
            rxNetLast = (i == n - 1);
            @(posedge ref_clk);
            if (rxNetReady) i++;
        end
        @(negedge ref_clk);
        rxNetValid = 1'b0;
        rxNetLast = 1'b0;
        rxNetByte = ~rxNetByte;
    endtask

    // completion report, flags {irq, jabber, underrun, collisions}
    task automatic report(input logic [3:0] f);
        @(negedge ref_clk);
        txDoneValid = 1'b1;
        txDoneFlags = f;
        @(negedge ref_clk);
        txDoneValid = 1'b0;
        txDoneFlags = ~f;
    endtask
endmodule // tsf_net_model
